// ---- rtl/dbs_pkg.sv ----
/*
  Constants and types for the DDR2 bank state and command legality block.
  Assumes a 40 MHz clock; timing counts derive from times in ns.
*/
package dbs_pkg;

  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned NUM_BANKS     = 8;
  localparam int unsigned BANK_W        = 3;
  localparam int unsigned CNT_W         = 8;

  // Times in ns, plain defaults
  localparam int unsigned T_WR_NS   = 15;
  localparam int unsigned T_RC_NS   = 60;
  localparam int unsigned T_MRD_NS  = 50;
  localparam int unsigned T_RP_NS   = 15;
  localparam int unsigned T_RCD_NS  = 15;

  // Least times round up
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [CNT_W-1:0] WR_CYC  = CNT_W'(ns_to_cyc(T_WR_NS));
  localparam logic [CNT_W-1:0] RC_CYC  = CNT_W'(ns_to_cyc(T_RC_NS));
  localparam logic [CNT_W-1:0] MRD_CYC = CNT_W'(ns_to_cyc(T_MRD_NS));
  localparam logic [CNT_W-1:0] RP_CYC  = CNT_W'(ns_to_cyc(T_RP_NS));
  localparam logic [CNT_W-1:0] RCD_CYC = CNT_W'(ns_to_cyc(T_RCD_NS));

  localparam int unsigned BL4        = 4;
  localparam int unsigned BL8        = 8;
  localparam int unsigned A10_BIT    = 10;
  localparam int unsigned A7_BIT     = 7;
  localparam int unsigned ADDR_W     = 14;
  localparam logic [1:0]  EMR2_SEL   = 2'h2;

  typedef enum logic [3:0] {
    DBS_CMD_DESELECT, DBS_CMD_NOP, DBS_CMD_READ, DBS_CMD_WRITE,
    DBS_CMD_ACT, DBS_CMD_PRE, DBS_CMD_REF, DBS_CMD_MRS
  } dbs_cmd_t;

  typedef enum logic [3:0] {
    DBS_IDLE, DBS_ROW_ACT, DBS_ACTIVE, DBS_READ, DBS_WRITE,
    DBS_WR_RECOV, DBS_WR_RECOV_AP, DBS_PRECHARGE, DBS_REFRESH, DBS_MODE_ACC
  } dbs_state_t;

endpackage

// ---- rtl/dbs_cmd_if.sv ----
/*
  Decoded command carrier between the top and the decoder.
  Assumes both ends on clock_i.
*/
`timescale 1ns/1ps
interface dbs_cmd_if;
  logic                cs_n;
  logic                ras_n;
  logic                cas_n;
  logic                we_n;
  dbs_pkg::dbs_cmd_t   cmd;

  modport dec (input cs_n, ras_n, cas_n, we_n, output cmd);
  modport top (output cs_n, ras_n, cas_n, we_n, input cmd);
endinterface

// ---- rtl/dbs_cmd_decode.sv ----
/*
  Command decoder from chip select, RAS, CAS and WE levels.
  Assumes inputs already synchronised to clock_i.
*/
`timescale 1ns/1ps
module dbs_cmd_decode (
  dbs_cmd_if.dec pins
);
  always_comb begin
    if (pins.cs_n)                                  pins.cmd = dbs_pkg::DBS_CMD_DESELECT; // [RULE9]
    else begin
      case ({pins.ras_n, pins.cas_n, pins.we_n})
        3'h7:    pins.cmd = dbs_pkg::DBS_CMD_NOP;   // [RULE9]
        3'h5:    pins.cmd = dbs_pkg::DBS_CMD_READ;
        3'h4:    pins.cmd = dbs_pkg::DBS_CMD_WRITE;
        3'h3:    pins.cmd = dbs_pkg::DBS_CMD_ACT;
        3'h2:    pins.cmd = dbs_pkg::DBS_CMD_PRE;
        3'h1:    pins.cmd = dbs_pkg::DBS_CMD_REF;
        3'h0:    pins.cmd = dbs_pkg::DBS_CMD_MRS;
        default: pins.cmd = dbs_pkg::DBS_CMD_NOP;   // Reserved code 3'h6 treated as no-op
      endcase
    end
  end
endmodule // dbs_cmd_decode

// ---- rtl/dbs_bank_ctrl.sv ----
/*
  Per-bank state tracking and command legality of a DDR2 device.
  Assumes command pins arrive from outside the clock domain.
*/
`timescale 1ns/1ps

// Summary of operation
// RULE1: Write recovery: no-op returns bank active after tWR; write restarts; rest illegal.
// RULE2: Write recovery with auto-precharge: no-op goes to precharge after tWR; all illegal.
// RULE3: Refresh allows only deselect or no-op; idle after tRC.
// RULE4: After mode register set only deselect or no-op until tMRD, then idle.
// RULE5: Command illegal for one bank may go to another bank allowing it.
// RULE6: Refresh, self refresh and mode set only with all banks idle.
// RULE7: Burst interrupt allowed only at burst length eight, never four.
// RULE8: Read interrupts read, write interrupts write, on four-bit boundary only.
// RULE9: Commands decoded from chip select, RAS, CAS, WE levels.
// RULE10: Above 85 degrees controller doubles refresh rate, 3.9 us interval; the model issues no periodic refresh.
// RULE11: EMR2 bit A7 set selects high-temperature self refresh.
// RULE12: Controller tracks bank timers and withholds illegal commands; the bench issues some on purpose and the block flags them on illegal_o.
module dbs_bank_ctrl #(
  parameter int unsigned NB = dbs_pkg::NUM_BANKS
) (
  input  wire logic                        clock_i,
  input  wire logic                        resetn_i,
  input  wire logic                        cs_n_i,
  input  wire logic                        ras_n_i,
  input  wire logic                        cas_n_i,
  input  wire logic                        we_n_i,
  input  wire logic [dbs_pkg::BANK_W-1:0]  bank_i,
  input  wire logic [dbs_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic                        burst8_i,
  output logic                             illegal_o,
  output logic      [NB-1:0]               bank_idle_o,
  output logic                             high_temp_sr_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers on all pins
  localparam int unsigned PW = 4 + dbs_pkg::BANK_W + dbs_pkg::ADDR_W + 1;
  logic [PW-1:0] s1_r, s2_r;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_r <= {PW{1'b1}};
      s2_r <= {PW{1'b1}};
    end else begin
      s1_r <= {cs_n_i, ras_n_i, cas_n_i, we_n_i, bank_i, addr_i, burst8_i};
      s2_r <= s1_r;
    end
  end

  logic                       burst8;
  logic [dbs_pkg::ADDR_W-1:0] addr;
  logic [dbs_pkg::BANK_W-1:0] bank;
  dbs_cmd_if                  cif();
  assign {cif.cs_n, cif.ras_n, cif.cas_n, cif.we_n, bank, addr, burst8} = s2_r;

  dbs_cmd_decode u_dec (
    .pins (cif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bank state
  dbs_pkg::dbs_state_t         st_r  [NB], st_nxt  [NB];
  logic [dbs_pkg::CNT_W-1:0]   cnt_r [NB], cnt_nxt [NB];
  logic [1:0]                  bcnt_r[NB], bcnt_nxt[NB];
  logic                        ap_r  [NB], ap_nxt  [NB];
  logic                        illegal_nxt;
  logic                        hts_r, hts_nxt;
  logic                        all_idle;
  logic [NB-1:0]               idle_nxt;

  function automatic logic [1:0] burst_beats(input logic b8);
    return b8 ? 2'h3 : 2'h1; // Cycles of four-bit halves minus one at 2 beats/clk
  endfunction

  always_comb begin
    all_idle = 1'b1;
    for (int i = 0; i < NB; i++) begin
      if (st_r[i] != dbs_pkg::DBS_IDLE) all_idle = 1'b0;
    end
  end

  always_comb begin
    logic sel, ap, tdone, ill;
    sel = 1'b0;
    ap = 1'b0;
    tdone = 1'b0;
    ill = 1'b0;
    illegal_nxt = 1'b0;
    hts_nxt = hts_r;
    for (int i = 0; i < NB; i++) begin
      sel   = (bank == dbs_pkg::BANK_W'(i));                                      // [RULE5]
      ap    = addr[dbs_pkg::A10_BIT];
      tdone = (cnt_r[i] <= dbs_pkg::CNT_W'(1));
      st_nxt[i]   = st_r[i];
      cnt_nxt[i]  = (cnt_r[i] != '0) ? cnt_r[i] - dbs_pkg::CNT_W'(1) : cnt_r[i];
      bcnt_nxt[i] = (bcnt_r[i] != 2'h0) ? bcnt_r[i] - 2'h1 : bcnt_r[i];
      ap_nxt[i]   = ap_r[i];
      ill = 1'b0;
      case (st_r[i])
        dbs_pkg::DBS_IDLE: begin
          if (sel && cif.cmd == dbs_pkg::DBS_CMD_ACT) begin
            st_nxt[i] = dbs_pkg::DBS_ROW_ACT;
            cnt_nxt[i] = dbs_pkg::RCD_CYC;
          end else if (cif.cmd == dbs_pkg::DBS_CMD_REF) begin
            if (all_idle) begin                                                    // [RULE6]
              st_nxt[i] = dbs_pkg::DBS_REFRESH;
              cnt_nxt[i] = dbs_pkg::RC_CYC;
            end else ill = 1'b1;
          end else if (cif.cmd == dbs_pkg::DBS_CMD_MRS) begin
            if (all_idle) begin                                                    // [RULE6]
              st_nxt[i] = dbs_pkg::DBS_MODE_ACC;
              cnt_nxt[i] = dbs_pkg::MRD_CYC;
            end else ill = 1'b1;
          end else if (sel && (cif.cmd == dbs_pkg::DBS_CMD_READ || cif.cmd == dbs_pkg::DBS_CMD_WRITE))
            ill = 1'b1;
        end
        dbs_pkg::DBS_ROW_ACT: begin
          if (tdone) st_nxt[i] = dbs_pkg::DBS_ACTIVE;
          if (sel && cif.cmd > dbs_pkg::DBS_CMD_NOP) ill = 1'b1;
        end
        dbs_pkg::DBS_ACTIVE, dbs_pkg::DBS_READ, dbs_pkg::DBS_WRITE: begin
          if (st_r[i] == dbs_pkg::DBS_WRITE && bcnt_r[i] == 2'h0) begin
            // Address bus has moved on by burst end, so use the held bit
            st_nxt[i] = ap_r[i] ? dbs_pkg::DBS_WR_RECOV_AP : dbs_pkg::DBS_WR_RECOV;
            cnt_nxt[i] = dbs_pkg::WR_CYC;
          end else if (st_r[i] == dbs_pkg::DBS_READ && bcnt_r[i] == 2'h0)
            st_nxt[i] = dbs_pkg::DBS_ACTIVE;
          if (sel && (cif.cmd == dbs_pkg::DBS_CMD_READ || cif.cmd == dbs_pkg::DBS_CMD_WRITE)) begin
            // Interrupt only same kind, BL8, on four-bit boundary
            if (st_r[i] != dbs_pkg::DBS_ACTIVE &&
                (!burst8 || bcnt_r[i][0] ||                                        // [RULE7] [RULE8]
                 (st_r[i] == dbs_pkg::DBS_READ) != (cif.cmd == dbs_pkg::DBS_CMD_READ)))
              ill = 1'b1;
            else begin
              st_nxt[i] = (cif.cmd == dbs_pkg::DBS_CMD_READ) ? dbs_pkg::DBS_READ : dbs_pkg::DBS_WRITE;
              bcnt_nxt[i] = burst_beats(burst8);
              ap_nxt[i] = ap;
            end
          end else if (sel && cif.cmd == dbs_pkg::DBS_CMD_PRE) begin
            if (st_r[i] == dbs_pkg::DBS_ACTIVE) begin
              st_nxt[i] = dbs_pkg::DBS_PRECHARGE;
              cnt_nxt[i] = dbs_pkg::RP_CYC;
            end else ill = 1'b1;
          end else if (sel && cif.cmd == dbs_pkg::DBS_CMD_ACT) ill = 1'b1;
          else if (cif.cmd == dbs_pkg::DBS_CMD_REF || cif.cmd == dbs_pkg::DBS_CMD_MRS) ill = 1'b1;
        end
        dbs_pkg::DBS_WR_RECOV: begin
          if (sel && cif.cmd == dbs_pkg::DBS_CMD_WRITE) begin                      // [RULE1]
            st_nxt[i] = dbs_pkg::DBS_WRITE;
            bcnt_nxt[i] = burst_beats(burst8);
            ap_nxt[i] = ap;
          end else begin
            if (tdone) st_nxt[i] = dbs_pkg::DBS_ACTIVE;                            // [RULE1]
            if ((sel && cif.cmd > dbs_pkg::DBS_CMD_NOP) ||
                cif.cmd == dbs_pkg::DBS_CMD_REF || cif.cmd == dbs_pkg::DBS_CMD_MRS) ill = 1'b1; // [RULE1]
          end
        end
        dbs_pkg::DBS_WR_RECOV_AP: begin
          if (tdone) begin                                                         // [RULE2]
            st_nxt[i] = dbs_pkg::DBS_PRECHARGE;
            cnt_nxt[i] = dbs_pkg::RP_CYC;
          end
          if ((sel && cif.cmd > dbs_pkg::DBS_CMD_NOP) ||
              cif.cmd == dbs_pkg::DBS_CMD_REF || cif.cmd == dbs_pkg::DBS_CMD_MRS) ill = 1'b1; // [RULE2]
        end
        dbs_pkg::DBS_PRECHARGE: begin
          if (tdone) st_nxt[i] = dbs_pkg::DBS_IDLE;
          if ((sel && cif.cmd > dbs_pkg::DBS_CMD_NOP && cif.cmd != dbs_pkg::DBS_CMD_PRE) ||
              cif.cmd == dbs_pkg::DBS_CMD_REF || cif.cmd == dbs_pkg::DBS_CMD_MRS) ill = 1'b1;
        end
        dbs_pkg::DBS_REFRESH: begin
          if (tdone) st_nxt[i] = dbs_pkg::DBS_IDLE;                                // [RULE3]
          if (cif.cmd > dbs_pkg::DBS_CMD_NOP) ill = 1'b1;                          // [RULE3]
        end
        dbs_pkg::DBS_MODE_ACC: begin
          if (tdone) st_nxt[i] = dbs_pkg::DBS_IDLE;                                // [RULE4]
          if (cif.cmd > dbs_pkg::DBS_CMD_NOP) ill = 1'b1;                          // [RULE4]
        end
        default: st_nxt[i] = dbs_pkg::DBS_IDLE;
      endcase
      // Illegal commands hold the bank in its current state for the cycle
      if (ill) begin
        st_nxt[i] = st_r[i];
        illegal_nxt = 1'b1;
      end
    end
    // High-temperature self refresh latched from EMR2 A7
    if (all_idle && cif.cmd == dbs_pkg::DBS_CMD_MRS && bank[1:0] == dbs_pkg::EMR2_SEL)
      hts_nxt = addr[dbs_pkg::A7_BIT];                                             // [RULE11]
    for (int i = 0; i < NB; i++) idle_nxt[i] = (st_nxt[i] == dbs_pkg::DBS_IDLE);
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NB; i++) begin
        st_r[i]   <= dbs_pkg::DBS_IDLE;
        cnt_r[i]  <= '0;
        bcnt_r[i] <= 2'h0;
        ap_r[i]   <= 1'b0;
      end
      illegal_o      <= 1'b0;
      bank_idle_o    <= '1;
      hts_r          <= 1'b0;
      high_temp_sr_o <= 1'b0;
    end else begin
      for (int i = 0; i < NB; i++) begin
        st_r[i]   <= st_nxt[i];
        cnt_r[i]  <= cnt_nxt[i];
        bcnt_r[i] <= bcnt_nxt[i];
        ap_r[i]   <= ap_nxt[i];
      end
      illegal_o      <= illegal_nxt;
      bank_idle_o    <= idle_nxt;
      hts_r          <= hts_nxt;
      high_temp_sr_o <= hts_nxt;
    end
  end

endmodule // dbs_bank_ctrl

// ---- tb/dbs_bank_ctrl_chk.sv ----
/*
  Port assertions for the bank state block.
  Assumes it is bound into dbs_bank_ctrl.
*/
`timescale 1ns/1ps
module dbs_bank_ctrl_chk #(
  parameter int unsigned NB = 8
) (
  input wire logic                       clock_i,
  input wire logic                       resetn_i,
  input wire logic                       cs_n_i,
  input wire logic                       ras_n_i,
  input wire logic                       cas_n_i,
  input wire logic                       we_n_i,
  input wire logic [dbs_pkg::BANK_W-1:0] bank_i,
  input wire logic [dbs_pkg::ADDR_W-1:0] addr_i,
  input wire logic                       burst8_i,
  input wire logic                       illegal_o,
  input wire logic [NB-1:0]              bank_idle_o,
  input wire logic                       high_temp_sr_o
);
  logic [3:0] c;
  logic [2:0] hist_r;
  logic [2:0] hist_nxt;
  logic       quiet;
  logic       all_idle;
  logic       ref_ok;
  logic       mrs_ok;
  ////////////////////////////////////////////////////////////
  // Idle output lags three cycles, so require a quiet history
  always_comb begin
    c        = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
    quiet    = cs_n_i | (c[2:0] == 3'h7);
    all_idle = &bank_idle_o;
    ref_ok   = (c == 4'h1) & all_idle & (&hist_r);
    mrs_ok   = (c == 4'h0) & all_idle & (&hist_r);
    hist_nxt = {hist_r[1:0], quiet};
  end
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) hist_r <= 3'h0;
    else hist_r <= hist_nxt;
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  a_nop_legal: assert property (quiet |-> ##3 !illegal_o)
    else $error("no-operation flagged illegal");
  a_act_claims: assert property ((c == 4'h3) && all_idle && (&hist_r) |->
    ##3 (!illegal_o && !bank_idle_o[$past(bank_i, 3)])) else $error("activate did not claim bank");
  a_ref_busy: assert property ((c == 4'h1) && !all_idle && (&hist_r) |-> ##3 illegal_o)
    else $error("refresh with open bank not flagged");
  a_ref_holds: assert property (ref_ok |-> ##3 (bank_idle_o == '0))
    else $error("banks idle during refresh");
  a_ref_blocks: assert property (ref_ok ##1 (c == 4'h5) |-> ##3 illegal_o)
    else $error("read during refresh not flagged");
  a_ref_done: assert property (ref_ok ##1 quiet [*8] |-> all_idle)
    else $error("refresh did not end");
  a_mrs_blocks: assert property (mrs_ok ##1 (c == 4'h3) |-> ##3 illegal_o)
    else $error("activate during mode delay not flagged");
  a_mrs_done: assert property (mrs_ok ##1 quiet [*6] |-> all_idle)
    else $error("mode delay did not end");
  a_emr2_temp: assert property (mrs_ok && (bank_i[1:0] == 2'h2) |->
    ##3 (high_temp_sr_o == $past(addr_i[7], 3))) else $error("high temperature flag wrong");
  c_ref: cover property (ref_ok);
  c_emr2: cover property (mrs_ok && (bank_i[1:0] == 2'h2) && addr_i[7]);
  c_ill: cover property (illegal_o);
  c_bl8: cover property (burst8_i && (c == 4'h4));
endmodule // dbs_bank_ctrl_chk

bind dbs_bank_ctrl dbs_bank_ctrl_chk #(.NB(NB)) u_chk (.clock_i(clock_i), .resetn_i(resetn_i),
  .cs_n_i(cs_n_i), .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i), .bank_i(bank_i),
  .addr_i(addr_i), .burst8_i(burst8_i), .illegal_o(illegal_o), .bank_idle_o(bank_idle_o),
  .high_temp_sr_o(high_temp_sr_o));

// ---- tb/dbs_ctl_model.sv ----
/*
  Memory controller model driving the command pins.
  Assumes the bench sequences it through its tasks.
*/
`timescale 1ns/1ps
module dbs_ctl_model (
  input  wire logic        clock_i,
  output logic      [3:0]  cmd_o,
  output logic      [2:0]  bank_o,
  output logic      [13:0] addr_o
);
  // Hot case needs twice the refresh rate; runs here are too short to refresh
  localparam int unsigned REFI_HOT_NS = 3900;
  initial begin
    cmd_o  = 4'hf;
    bank_o = 3'h0;
    addr_o = 14'h0;
  end
  // Pins are cs, ras, cas, we in that order
  // Bank timers tracked by the caller; the caller may cut bursts short
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    @(posedge clock_i);
    cmd_o  <= c;
    bank_o <= b;
    addr_o <= a;
  endtask
  // Refresh and mode set are issued only after idle waits
  task automatic idle(input int n);
    @(posedge clock_i);
    cmd_o  <= 4'h7;
    addr_o <= ~addr_o;
    repeat (n - 1) @(posedge clock_i);
  endtask
endmodule // dbs_ctl_model

// ---- tb/tb_ddr2_bank_state_command_rules.sv ----
/*
  Self-checking bench for the bank state block.
  Assumes dbs_ctl_model drives the command pins.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_ddr2_bank_state_command_rules;
  logic        clock_i;
  logic        resetn_i;
  logic        burst8_i;
  logic [3:0]  cmd;
  logic [2:0]  bank;
  logic [13:0] addr;
  logic        illegal_o;
  logic        high_temp_sr_o;
  logic [7:0]  bank_idle_o;
  int          errors = 0;
  int          comparisons = 0;
  int          ill_cnt = 0;
  int          base;
  dbs_ctl_model u_ctl (.clock_i(clock_i), .cmd_o(cmd), .bank_o(bank), .addr_o(addr));
  dbs_bank_ctrl u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .cs_n_i(cmd[3]), .ras_n_i(cmd[2]),
    .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .bank_i(bank), .addr_i(addr), .burst8_i(burst8_i),
    .illegal_o(illegal_o), .bank_idle_o(bank_idle_o), .high_temp_sr_o(high_temp_sr_o));
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) if (illegal_o === 1'b1) ill_cnt++;
  ////////////////////////////////////////////////////////////
  task automatic t_refresh;
    base = ill_cnt;
    u_ctl.idle(4);
    u_ctl.issue(4'h1, 3'h0, 14'h0);
    u_ctl.issue(4'h5, 3'h3, 14'h0);
    u_ctl.idle(2);
    #1 `CHK("idle in refresh", 8'h00, bank_idle_o)
    u_ctl.idle(8);
    #1 `CHK("idle after refresh", 8'hff, bank_idle_o)
    `CHK("refresh illegal count", 1, ill_cnt - base)
    $display("refresh test done");
  endtask
  task automatic t_mode;
    base = ill_cnt;
    u_ctl.issue(4'h0, 3'h2, 14'h0080);
    u_ctl.issue(4'h3, 3'h0, 14'h0);
    u_ctl.idle(6);
    #1 `CHK("idle after mode set", 8'hff, bank_idle_o)
    `CHK("mode illegal count", 1, ill_cnt - base)
    `CHK("high temp set", 1'b1, high_temp_sr_o)
    u_ctl.issue(4'h0, 3'h1, 14'h0);
    u_ctl.idle(6);
    #1 `CHK("other register keeps temp", 1'b1, high_temp_sr_o)
    u_ctl.issue(4'h0, 3'h2, 14'h0);
    u_ctl.idle(6);
    #1 `CHK("high temp clear", 1'b0, high_temp_sr_o)
    $display("mode test done");
  endtask
  task automatic t_banks;
    base = ill_cnt;
    u_ctl.issue(4'h3, 3'h0, 14'h0);
    u_ctl.issue(4'h3, 3'h1, 14'h0);
    u_ctl.idle(4);
    #1 `CHK("two banks open", 8'hfc, bank_idle_o)
    u_ctl.issue(4'h1, 3'h0, 14'h0);
    u_ctl.idle(5);
    #1 `CHK("bank illegal count", 1, ill_cnt - base)
    u_ctl.issue(4'h2, 3'h0, 14'h0);
    u_ctl.issue(4'h2, 3'h1, 14'h0);
    u_ctl.idle(5);
    #1 `CHK("banks closed", 8'hff, bank_idle_o)
    $display("bank test done");
  endtask
  task automatic t_write;
    base = ill_cnt;
    u_ctl.issue(4'h3, 3'h2, 14'h0);
    u_ctl.idle(3);
    u_ctl.issue(4'h4, 3'h2, 14'h0);
    u_ctl.idle(2);
    // Timed to land in the one-cycle write recovery
    u_ctl.issue(4'h5, 3'h2, 14'h0);
    u_ctl.idle(8);
    u_ctl.issue(4'h5, 3'h2, 14'h0);
    u_ctl.idle(6);
    u_ctl.issue(4'h4, 3'h2, 14'h0123);
    u_ctl.idle(2);
    u_ctl.issue(4'h4, 3'h2, 14'h0246);
    u_ctl.idle(8);
    #1 `CHK("write recovery count", 1, ill_cnt - base)
    `CHK("open after new write", 8'hfb, bank_idle_o)
    base = ill_cnt;
    u_ctl.issue(4'h4, 3'h2, 14'h0400);
    u_ctl.idle(2);
    u_ctl.issue(4'h4, 3'h2, 14'h0);
    u_ctl.idle(10);
    #1 `CHK("auto precharge count", 1, ill_cnt - base)
    `CHK("idle after auto precharge", 8'hff, bank_idle_o)
    $display("write test done");
  endtask
  task automatic t_burst;
    base = ill_cnt;
    u_ctl.issue(4'h3, 3'h5, 14'h1555);
    u_ctl.idle(3);
    @(posedge clock_i) burst8_i <= 1'b1;
    u_ctl.issue(4'h4, 3'h5, 14'h0123);
    u_ctl.issue(4'h4, 3'h5, 14'h0089);
    u_ctl.issue(4'h4, 3'h5, 14'h0312);
    u_ctl.idle(1);
    u_ctl.issue(4'h5, 3'h5, 14'h0054);
    u_ctl.idle(8);
    #1 `CHK("bl8 interrupt count", 2, ill_cnt - base)
    `CHK("bank five open", 8'hdf, bank_idle_o)
    base = ill_cnt;
    @(posedge clock_i) burst8_i <= 1'b0;
    u_ctl.issue(4'h4, 3'h5, 14'h0021);
    u_ctl.issue(4'h4, 3'h5, 14'h0042);
    u_ctl.idle(8);
    u_ctl.issue(4'h2, 3'h5, 14'h0);
    u_ctl.idle(4);
    #1 `CHK("bl4 interrupt count", 1, ill_cnt - base)
    `CHK("bank five closed", 8'hff, bank_idle_o)
    $display("burst test done");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Whole run is under 150 cycles
  initial begin
    #20us;
    errors++;
    $display("ERROR watchdog expired");
    wrap_up;
  end
  initial begin
    resetn_i = 1'b0;
    burst8_i = 1'b0;
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b1;
    t_refresh;
    t_mode;
    t_banks;
    t_write;
    t_burst;
    wrap_up;
  end
endmodule // tb_ddr2_bank_state_command_rules
